/* rtl/atcs_top.sv */
// Purpose: control, filter, enable and status logic of a timer
// Assumes: counter core, capture logic and break polarity outside
// Notes:   zero-wait APB slave; unmapped addresses give pslverr
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module atcs_top #(
  parameter int ARR_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter core events
  input wire logic cnt_wrap,
  input wire logic count_up,
  input wire logic force_update,
  input wire logic slave_update,
  input wire logic slave_reset,
  input wire logic [2:0] slave_mode,
  input wire logic encoder_mode,
  input wire logic trigger_in_rise,
  input wire logic trigger_in_fall,
  input wire logic trigger_gen,
  input wire logic commutation_evt,
  // auto-reload value
  input wire logic arr_wr,
  input wire logic [ARR_W-1:0] arr_wdata,
  output logic [ARR_W-1:0] arr_active,
  // counter control
  output logic counter_run,
  output logic count_down,
  output logic [1:0] align_select,
  output logic update_event,
  output logic counter_reinit,
  // channels
  input wire logic [3:0] chan_is_input,
  input wire logic [3:0] capture_evt,
  input wire logic [3:0] match_evt,
  input wire logic [3:0] capture_read,
  input wire logic [3:0] chan_in,
  output logic [3:0] chan_filt,
  input wire logic [3:0] oc_ref,
  output logic [3:0] out_ch,
  output logic [3:0] out_ch_inv,
  // break and dead-time
  input wire logic break_in,
  input wire logic break_gen,
  input wire logic [1:0] lock_level,
  input wire logic [7:0] dead_len,
  // interrupt request
  output logic timer_irq
);
  import atcs_pkg::*;

  typedef struct packed {
    logic [17:0] ctrl;
    logic [15:0] filt;
    logic [7:0] ien;
    logic [11:0] flags;
    logic main_output_on;
    atcs_out_e ost;
    logic [7:0] dt_cnt;
    logic [1:0] div;
    logic [4:0] pre;
    logic [ARR_W-1:0] arr_pre;
    logic [ARR_W-1:0] arr_act;
    logic [3:0] oc;
    logic [3:0] ocn;
    logic [31:0] rdata;
  } atcs_top_s;

  atcs_top_s st_r;
  atcs_top_s st_nxt;

  logic wr_acc;
  logic rd_set;
  logic map_hit;
  logic ue;
  logic dts_tick;
  logic trig_evt;
  logic brk_evt;
  logic [1:0] ratio;
  logic [1:0] align;
  logic [1:0] div_mask;
  logic [3:0] cmp_ok;
  logic [3:0] samp_en;
  logic [7:0] idle_bits;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // decode and events
  // ----------------------------------------------------------------
  assign ratio = st_r.ctrl[ATCS_B_RATIO +: 2];
  assign align = st_r.ctrl[ATCS_B_ALIGN +: 2];
  assign idle_bits = st_r.ctrl[ATCS_B_IDLE +: 8];
  assign map_hit = (paddr == ATCS_OFS_CTRL) || (paddr == ATCS_OFS_FILT)
    || (paddr == ATCS_OFS_IEN) || (paddr == ATCS_OFS_FLAGS)
    || (paddr == ATCS_OFS_OUTEN);
  assign wr_acc = psel && penable && pwrite && map_hit;
  assign rd_set = psel && !penable && !pwrite;
  // update blocked entirely while update_block is set
  assign ue = !st_r.ctrl[ATCS_B_UBLK]
    && (cnt_wrap || force_update || slave_update);
  // gated mode reports both edges, other modes except off only the rising one
  assign trig_evt = trigger_gen
    || ((slave_mode == ATCS_SM_GATED)
      ? (trigger_in_rise || trigger_in_fall)
      : ((slave_mode != ATCS_SM_OFF) && trigger_in_rise));
  assign brk_evt = break_in || break_gen;

  // filter clock divider: code 11 is reserved and runs as 00
  always_comb begin
    case (ratio)
      2'b01: div_mask = 2'b01;
      2'b10: div_mask = 2'b11;
      default: div_mask = 2'b00;
    endcase
  end
  assign dts_tick = (st_r.div & div_mask) == div_mask;

  // per-channel sample strobes from the filter codes
  always_comb begin
    logic [3:0] code;
    code = 4'h0;
    for (int i = 0; i < 4; i++) begin
      code = st_r.filt[4*i +: 4];
      case (code)
        4'h0: samp_en[i] = dts_tick;
        4'h1, 4'h2, 4'h3: samp_en[i] = 1'b1;
        4'h4, 4'h5: samp_en[i] = dts_tick && st_r.pre[0];
        4'h6, 4'h7: samp_en[i] = dts_tick && (&st_r.pre[1:0]);
        4'h8, 4'h9: samp_en[i] = dts_tick && (&st_r.pre[2:0]);
        4'hA, 4'hB, 4'hC: samp_en[i] = dts_tick && (&st_r.pre[3:0]);
        default: samp_en[i] = dts_tick && (&st_r.pre);
      endcase
    end
  end

  // compare flags only in the counting direction the mode allows
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (align)
        2'b01: cmp_ok[i] = !count_up;
        2'b10: cmp_ok[i] = count_up;
        default: cmp_ok[i] = 1'b1;
      endcase
      cmp_ok[i] = cmp_ok[i] && match_evt[i] && !chan_is_input[i];
    end
  end

  // ----------------------------------------------------------------
  // filter instances
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_filt
    atcs_chan_filter u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .sample_en(samp_en[g]),
      .n_len(ATCS_FILT_N[4*st_r.filt[4*g +: 4] +: 4]),
      .din(chan_in[g]),
      .dout(chan_filt[g])
    );
  end

  // read data multiplexer; unused bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ATCS_OFS_CTRL: rd_mux[ATCS_CTRL_W-1:0] = st_r.ctrl;
      ATCS_OFS_FILT: rd_mux[15:0] = st_r.filt;
      ATCS_OFS_IEN: rd_mux[7:0] = st_r.ien;
      ATCS_OFS_FLAGS: rd_mux[11:0] = st_r.flags;
      ATCS_OFS_OUTEN: rd_mux[0] = st_r.main_output_on;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [17:0] wmask;
    logic [11:0] setf;
    wmask = 18'h3_FFFF;
    setf = 12'h000;
    st_nxt = st_r;
    st_nxt.div = st_r.div + 2'd1;
    if (dts_tick) begin
      st_nxt.pre = st_r.pre + 5'd1;
    end
    if (rd_set) begin
      st_nxt.rdata = rd_mux;
    end
    // software writes
    if (wr_acc) begin
      case (paddr)
        ATCS_OFS_CTRL: begin
          if (lock_level != 2'b00) begin
            wmask = wmask & ~ATCS_IDLE_MASK;
          end
          if ((align != 2'b00) || encoder_mode) begin
            wmask[ATCS_B_DIR] = 1'b0;
          end
          st_nxt.ctrl = (st_r.ctrl & ~wmask)
            | (pwdata[ATCS_CTRL_W-1:0] & wmask);
        end
        ATCS_OFS_FILT: st_nxt.filt = pwdata[15:0];
        ATCS_OFS_IEN: st_nxt.ien = pwdata[7:0];
        ATCS_OFS_FLAGS: begin
          // write zero clears, write one leaves the flag alone
          st_nxt.flags = st_r.flags & pwdata[11:0];
          if (break_in) begin
            st_nxt.flags[ATCS_B_BRK] = st_r.flags[ATCS_B_BRK];
          end
        end
        ATCS_OFS_OUTEN: st_nxt.main_output_on = pwdata[0];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    // hardware control of the run bit
    if ((slave_mode == ATCS_SM_TRIG) && trigger_in_rise) begin
      st_nxt.ctrl[ATCS_B_RUN] = 1'b1;
    end
    if (ue && st_r.ctrl[ATCS_B_SHOT]) begin
      st_nxt.ctrl[ATCS_B_RUN] = 1'b0;
    end
    // auto-reload shadowing
    if (arr_wr) begin
      st_nxt.arr_pre = arr_wdata;
      if (!st_r.ctrl[ATCS_B_RLBUF]) begin
        st_nxt.arr_act = arr_wdata;
      end
    end
    if (ue) begin
      st_nxt.arr_act = st_r.arr_pre;
    end
    // hardware flag sets, applied after the clear so a set wins
    setf[0] = ue && (cnt_wrap || !st_r.ctrl[ATCS_B_ULIM]);
    setf[4:1] = capture_evt | cmp_ok;
    setf[5] = commutation_evt;
    setf[ATCS_B_TRG] = trig_evt;
    setf[ATCS_B_BRK] = brk_evt;
    setf[11:8] = capture_evt & chan_is_input & st_r.flags[4:1];
    st_nxt.flags[4:1] = st_nxt.flags[4:1] & ~capture_read;
    st_nxt.flags = st_nxt.flags | setf;
    // break drops the main output enable
    if (brk_evt) begin
      st_nxt.main_output_on = 1'b0;
    end
    // output stage
    case (st_r.ost)
      ATCS_OUT_RUN: begin
        st_nxt.oc = oc_ref;
        st_nxt.ocn = ~oc_ref;
        if (!st_r.main_output_on) begin
          st_nxt.ost = ATCS_OUT_DEAD;
          st_nxt.dt_cnt = dead_len;
          st_nxt.oc = 4'h0;
          st_nxt.ocn = 4'h0;
        end
      end
      ATCS_OUT_DEAD: begin
        // both sides low while the dead-time runs out
        if (st_r.main_output_on) begin
          st_nxt.ost = ATCS_OUT_RUN;
        end else if (dts_tick) begin
          if (st_r.dt_cnt == 8'h00) begin
            st_nxt.ost = ATCS_OUT_IDLE;
          end else begin
            st_nxt.dt_cnt = st_r.dt_cnt - 8'h01;
          end
        end
      end
      ATCS_OUT_IDLE: begin
        for (int i = 0; i < 4; i++) begin
          st_nxt.oc[i] = idle_bits[2*i];
          st_nxt.ocn[i] = idle_bits[2*i+1];
        end
        if (st_r.main_output_on) begin
          st_nxt.ost = ATCS_OUT_RUN;
        end
      end
      default: st_nxt.ost = ATCS_OUT_RUN;
    endcase
  end

  // state register; every field resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_hit;
  assign counter_run = st_r.ctrl[ATCS_B_RUN];
  assign count_down = st_r.ctrl[ATCS_B_DIR];
  assign align_select = align;
  assign update_event = ue;
  // reinit works even while updates are blocked
  assign counter_reinit = force_update || slave_reset;
  assign arr_active = st_r.arr_act;
  assign out_ch = st_r.oc;
  assign out_ch_inv = st_r.ocn;
  assign timer_irq = |(st_r.flags[7:0] & st_r.ien);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_idle_lock: assert property (
    wr_acc && (paddr == ATCS_OFS_CTRL) && (lock_level != 2'b00)
    |=> $stable(st_r.ctrl[17:10]))
    else $error("idle bits changed under lock");
  a_dir_ro: assert property (
    wr_acc && (paddr == ATCS_OFS_CTRL) && (align != 2'b00)
    |=> count_down == $past(count_down))
    else $error("direction written in center mode");
  a_shot_stop: assert property (
    ue && st_r.ctrl[ATCS_B_SHOT] && !trigger_in_rise |=> !counter_run)
    else $error("single shot did not stop");
  a_ulim_flag: assert property (
    st_r.ctrl[ATCS_B_ULIM] && force_update && !cnt_wrap
    && !st_r.flags[0] |=> !st_r.flags[0])
    else $error("update flag set by software update");
  a_ublk_none: assert property (
    st_r.ctrl[ATCS_B_UBLK] |-> !update_event)
    else $error("update event while blocked");
  a_trig_run: assert property (
    (slave_mode == ATCS_SM_TRIG) && trigger_in_rise |=> counter_run)
    else $error("trigger mode did not start counter");
  a_ovc_set: assert property (
    capture_evt[0] && chan_is_input[0] && st_r.flags[1]
    |=> st_r.flags[8])
    else $error("overcapture flag missed");
  a_brk_hold: assert property (
    break_in |=> st_r.flags[ATCS_B_BRK] && !st_r.main_output_on)
    else $error("break flag or output enable wrong");
  a_idle_out: assert property (
    $fell(st_r.main_output_on) && (dead_len == 8'h00)
    && (lock_level != 2'b00) && !st_nxt.main_output_on
    ##1 !st_r.main_output_on [*8]
    |-> out_ch_inv == {idle_bits[7], idle_bits[5], idle_bits[3],
      idle_bits[1]})
    else $error("complementary outputs not at idle level");
  a_irq_pair: assert property (
    |(st_r.flags[7:0] & st_r.ien) |-> timer_irq)
    else $error("interrupt not raised");

  logic setf_cover_ovc;
  assign setf_cover_ovc = |(capture_evt & chan_is_input & st_r.flags[4:1]);

  c_break: cover property (break_in ##1 timer_irq);
  c_shot: cover property (ue && st_r.ctrl[ATCS_B_SHOT]);
  c_ovc: cover property (setf_cover_ovc);
  c_idle: cover property (st_r.ost == ATCS_OUT_IDLE);

endmodule

/* rtl/atcs_pkg.sv */
// Purpose: shared constants for the timer control/status block
// Assumes: 32-bit APB data, one word per register
// Notes:   filter length table packed four bits per code
package atcs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ATCS_OFS_CTRL = 8'h00;
  localparam logic [7:0] ATCS_OFS_FILT = 8'h04;
  localparam logic [7:0] ATCS_OFS_IEN = 8'h08;
  localparam logic [7:0] ATCS_OFS_FLAGS = 8'h0C;
  localparam logic [7:0] ATCS_OFS_OUTEN = 8'h10;

  // ----------------------------------------------------------------
  // control and flag fields
  // ----------------------------------------------------------------
  localparam int ATCS_CTRL_W = 18;
  localparam int ATCS_B_RUN = 0;
  localparam int ATCS_B_UBLK = 1;
  localparam int ATCS_B_ULIM = 2;
  localparam int ATCS_B_SHOT = 3;
  localparam int ATCS_B_DIR = 4;
  localparam int ATCS_B_ALIGN = 5;
  localparam int ATCS_B_RLBUF = 7;
  localparam int ATCS_B_RATIO = 8;
  localparam int ATCS_B_IDLE = 10;
  localparam int ATCS_B_BRK = 7;
  localparam int ATCS_B_TRG = 6;
  localparam int ATCS_B_OVC = 8;
  localparam logic [17:0] ATCS_IDLE_MASK = 18'h3_FC00;
  localparam logic [17:0] ATCS_CTRL_RST = 18'h0_0000;
  localparam logic [15:0] ATCS_FILT_RST = 16'h0000;
  localparam logic [7:0] ATCS_IEN_RST = 8'h00;
  localparam logic [11:0] ATCS_FLAGS_RST = 12'h000;

  // ----------------------------------------------------------------
  // slave modes and filter lengths
  // ----------------------------------------------------------------
  localparam logic [2:0] ATCS_SM_GATED = 3'h5;
  localparam logic [2:0] ATCS_SM_TRIG = 3'h6;
  localparam logic [2:0] ATCS_SM_OFF = 3'h0;
  // lengths for codes 15..0, four bits each
  localparam logic [63:0] ATCS_FILT_N = 64'h8658_6586_8686_8421;

  typedef enum logic [1:0] {ATCS_OUT_RUN, ATCS_OUT_DEAD, ATCS_OUT_IDLE}
    atcs_out_e;

endpackage

/* rtl/atcs_chan_filter.sv */
// Purpose: one channel input filter, N agreeing samples per change
// Assumes: sample_en is a one-cycle pulse at the sampling rate
// Notes:   n_len of 1 passes each sample straight through
`timescale 1ns/1ps
module atcs_chan_filter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sampling control
  input wire logic sample_en,
  input wire logic [3:0] n_len,
  // data
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic level;
    logic [3:0] run;
  } atcs_filt_s;

  atcs_filt_s st_r;
  atcs_filt_s st_nxt;

  // ----------------------------------------------------------------
  // agreement counter
  // ----------------------------------------------------------------
  // run counts samples that differ from the output; any agreeing
  // sample restarts it, so glitches shorter than N never pass
  always_comb begin
    st_nxt = st_r;
    if (sample_en) begin
      if (din == st_r.level) begin
        st_nxt.run = 4'h0;
      end else if (st_r.run + 4'h1 >= n_len) begin
        st_nxt.level = din;
        st_nxt.run = 4'h0;
      end else begin
        st_nxt.run = st_r.run + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.level;

endmodule

/* bench/atcs_pins.sv */
// Purpose: far-side model of the channel and break pins
// Assumes: pins change only right after a kernel clock edge
// Notes:   levels registered, so they never move mid-cycle
`timescale 1ns/1ps
module atcs_pins (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic brk_req,
  input wire logic [3:0] lvl,
  // pins toward the block
  output logic [3:0] chan_in,
  output logic break_in
);
  // ----
  // pin drivers
  // ----
  // one edge of latency, like a real pad synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_in <= 4'h0;
      break_in <= 1'b0;
    end else begin
      chan_in <= lvl;
      break_in <= brk_req;
    end
  end
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench for the timer control/status block
// Assumes: zero-wait apb slave, flags set one edge after an event
// Notes:   expectations built from field positions, not the design
`timescale 1ns/1ps
module tb;
  import atcs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [13:0] ev = '0;
  logic [15:0] arr_wdata = 16'h0000;
  logic [2:0] slave_mode = 3'h0;
  logic [3:0] is_in = 4'h0;
  logic [3:0] oc_ref = 4'h0;
  logic [1:0] lock_level = 2'h0;
  logic [7:0] dead_len = 8'h02;
  logic brk_req = 1'b0;
  logic [3:0] pin_lvl = 4'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, err, counter_run, count_down, update_event;
  logic counter_reinit, break_in, timer_irq;
  logic [15:0] arr_active;
  logic [1:0] align_select;
  logic [3:0] chan_in, chan_filt, out_ch, out_ch_inv;
  logic [7:0] idl;
  int errors = 0;
  int samples_checked = 0;

  always #4 pclk = ~pclk;

  atcs_pins pins (.pclk(pclk), .presetn(presetn), .brk_req(brk_req),
    .lvl(pin_lvl), .chan_in(chan_in), .break_in(break_in));

  atcs_top #(.ARR_W(16)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cnt_wrap(ev[0]), .count_up(1'b0),
    .force_update(ev[1]), .slave_update(ev[2]), .slave_reset(ev[3]),
    .slave_mode(slave_mode), .encoder_mode(1'b0),
    .trigger_in_rise(ev[4]), .trigger_in_fall(ev[5]),
    .trigger_gen(ev[6]), .commutation_evt(ev[7]), .arr_wr(ev[9]),
    .arr_wdata(arr_wdata), .arr_active(arr_active),
    .counter_run(counter_run), .count_down(count_down),
    .align_select(align_select), .update_event(update_event),
    .counter_reinit(counter_reinit), .chan_is_input(is_in),
    .capture_evt(ev[13:10]), .match_evt(4'h0), .capture_read(4'h0),
    .chan_in(chan_in), .chan_filt(chan_filt), .oc_ref(oc_ref),
    .out_ch(out_ch), .out_ch_inv(out_ch_inv), .break_in(break_in),
    .break_gen(ev[8]), .lock_level(lock_level), .dead_len(dead_len),
    .timer_irq(timer_irq));

  // ----
  // shared tasks
  // ----
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // return half a cycle on, so callers see settled outputs
    @(negedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= '0;
    @(negedge pclk);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 60 && out_ch !== {idl[6], idl[4], idl[2], idl[0]};
         i++) @(posedge pclk);
    chk({28'h0, out_ch}, {28'h0, idl[6], idl[4], idl[2], idl[0]});
    chk({28'h0, out_ch_inv}, {28'h0, idl[7], idl[5], idl[3], idl[1]});
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h0000_02A9));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rchk(8'(4 * i), 32'h0000_0000);
    apb(1'b1, ATCS_OFS_FILT, '1);
    rchk(ATCS_OFS_FILT, 32'h0000_FFFF);
    apb(1'b1, ATCS_OFS_IEN, '1);
    rchk(ATCS_OFS_IEN, 32'h0000_00FF);
    apb(1'b1, 8'h40, 32'h0000_0001);
    chk({31'h0, err}, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      apb(1'b1, ATCS_OFS_FILT, v);
      rchk(ATCS_OFS_FILT, v & 32'h0000_FFFF);
    end
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ATCS_OFS_CTRL, 32'(r) << ATCS_B_RATIO);
      rchk(ATCS_OFS_CTRL, 32'(r) << ATCS_B_RATIO);
    end
    $display("test registers done");
    // filters: code 0 passes quickly, code 15 needs 8 slow samples
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_FILT, 32'h0000_0000);
    pin_lvl <= 4'h5;
    for (int i = 0; i < 20 && chan_filt !== 4'h5; i++) @(posedge pclk);
    chk({28'h0, chan_filt}, 32'h0000_0005);
    apb(1'b1, ATCS_OFS_FILT, 32'h0000_FFFF);
    pin_lvl <= 4'hA;
    repeat (100) @(posedge pclk);
    chk({28'h0, chan_filt}, 32'h0000_0005);
    for (int i = 0; i < 400 && chan_filt !== 4'hA; i++) @(posedge pclk);
    chk({28'h0, chan_filt}, 32'h0000_000A);
    $display("test filters done");
    // reload buffering and update blocking
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0080);
    arr_wdata <= 16'h1234;
    pulse(9);
    chk({16'h0, arr_active}, 32'h0000_0000);
    pulse(0);
    chk({16'h0, arr_active}, 32'h0000_1234);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0082);
    ev[1] <= 1'b1;
    @(negedge pclk);
    chk({31'h0, update_event}, 32'h0000_0000);
    ev <= '0;
    arr_wdata <= 16'h5678;
    pulse(9);
    pulse(0);
    chk({16'h0, arr_active}, 32'h0000_1234);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0000);
    arr_wdata <= 16'h9ABC;
    pulse(9);
    chk({16'h0, arr_active}, 32'h0000_9ABC);
    $display("test reload done");
    // update sources and interrupt gating
    apb(1'b1, ATCS_OFS_IEN, 32'h0000_0001);
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0004);
    ev[1] <= 1'b1;
    @(negedge pclk);
    chk({31'h0, update_event}, 32'h0000_0001);
    chk({31'h0, counter_reinit}, 32'h0000_0001);
    ev <= '0;
    rchk(ATCS_OFS_FLAGS, 32'h0000_0000);
    chk({31'h0, timer_irq}, 32'h0000_0000);
    pulse(0);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0001);
    chk({31'h0, timer_irq}, 32'h0000_0001);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    chk({31'h0, timer_irq}, 32'h0000_0000);
    pulse(2);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0001);
    $display("test update done");
    // single shot, trigger start, gated falling edge
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0009);
    chk({31'h0, counter_run}, 32'h0000_0001);
    pulse(0);
    chk({31'h0, counter_run}, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    slave_mode <= ATCS_SM_TRIG;
    pulse(4);
    chk({31'h0, counter_run}, 32'h0000_0001);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0040);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    slave_mode <= ATCS_SM_GATED;
    pulse(5);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0040);
    slave_mode <= ATCS_SM_OFF;
    // align changed only while stopped; direction locked
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0020);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0030);
    rchk(ATCS_OFS_CTRL, 32'h0000_0020);
    chk({30'h0, align_select}, 32'h0000_0001);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_CTRL, 32'h0000_0010);
    chk({31'h0, count_down}, 32'h0000_0001);
    $display("test control done");
    // overcapture set and cleared
    is_in <= 4'hF;
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    pulse(10);
    pulse(10);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0102);
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0EFF);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0002);
    // idle levels after output enable drop, then after break
    idl = 8'($urandom);
    oc_ref <= 4'($urandom);
    apb(1'b1, ATCS_OFS_CTRL, {14'h0, idl, 10'h000});
    apb(1'b1, ATCS_OFS_OUTEN, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    chk({28'h0, out_ch_inv}, {28'h0, ~oc_ref});
    chk({28'h0, out_ch}, {28'h0, oc_ref});
    apb(1'b1, ATCS_OFS_OUTEN, 32'h0000_0000);
    wait_idle();
    // no dead-time and locked idle bits for the break drop
    dead_len <= 8'h00;
    lock_level <= 2'h1;
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_OUTEN, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    brk_req <= 1'b1;
    wait_idle();
    rchk(ATCS_OFS_OUTEN, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0080);
    brk_req <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b1, ATCS_OFS_FLAGS, 32'h0000_0000);
    rchk(ATCS_OFS_FLAGS, 32'h0000_0000);
    apb(1'b1, ATCS_OFS_CTRL, {14'h0, ~idl, 10'h000});
    rchk(ATCS_OFS_CTRL, {14'h0, idl, 10'h000});
    $display("test outputs done");
    tally_and_finish();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end
endmodule
